// >>> hdl/vtp_pkg.sv
// Purpose: shared constants and types of the voice tdm codec port
// Assumes: 16-bit word registers on the dsp side, 32 slots per frame
// Notes: all offsets are word indices on the dsp data bus
package vtp_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned SYS_HZ = 200_000_000;
    localparam int unsigned BCLK_HZ = 2_048_000;
    // half bit period rounds down, so the clock is never slower
    localparam int unsigned HALF_DIV = SYS_HZ / (2 * BCLK_HZ);
    localparam logic [6:0] HALF_CNT = 7'(HALF_DIV - 1);
    localparam logic [7:0] FS_BITS = 8'h08;
    localparam int NCH = 4;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] A_RESET = 5'h00;
    localparam logic [4:0] A_CFG = 5'h02;
    localparam logic [2:0] A_UP_SLOT = 3'h1;
    localparam logic [2:0] A_DN_SLOT = 3'h2;
    localparam logic [4:0] A_INT = 5'h0c;
    localparam logic [2:0] A_UP_PCM = 3'h4;
    localparam logic [2:0] A_DN_PCM = 3'h5;
    localparam logic [2:0] A_UP_LIN = 3'h6;
    localparam logic [2:0] A_DN_LIN = 3'h7;

    localparam int CFG_SRST = 0;
    localparam int CFG_LIN = 1;
    localparam int CFG_CLKSRC = 2;
    localparam int CFG_FSSRC = 3;
    localparam logic [3:0] CFG_RST = 4'h0;
    localparam int INT_OVR = 0;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic unread;
        logic [1:0] ch;
        logic [15:0] data;
    } vtp_smp_t;

    typedef struct packed {
        logic lin;
        logic [1:0] ch;
        logic [15:0] data;
    } vtp_dnwr_t;

endpackage

// >>> hdl/vtp_port.sv
// Purpose: four channel serial voice port with double buffered samples
// Assumes: one system clock; codec pins sampled through two flip-flops
// Notes: fifo in front of the downstream bank absorbs dsp write bursts
//
// What this block does
// - shift downstream bits out on ser_data_out, take upstream bits in
// - bit clock generated from master clock or taken in, per config
// - frame sync high during slot zero, generated or taken in
// - both directions share one bit counter, so frames stay aligned
// - all logic except the pin synchronisers and fifo storage is reset while hw_reset_n is low
// - exactly two interrupt outputs: overrun and frame sync
// - fully synchronous, no gated clocks, no latches
// - dsp bus side decoupled from the serial timing
// - software reset bit in the configuration register at 0x0002
// - linear bit selects companded 8-bit or 16-bit linear coding
// - two identical banks of four samples per direction
// - samples are 8 or 16 bits, plus channel number bits
// - banks swap at each frame start; dsp sees fixed addresses
// - internal time base builds the frame sync timing
// - programmable slot number per channel and direction
// - frame sync forwarded as the frame interrupt
// - companded storage is 8 sample bits plus 3 auxiliary bits
// - codec fills on-line upstream bank, dsp reads off-line one
// - unread upstream data at swap sets the overrun flag
// - linear: high byte in programmed slot, low byte in the next
// - downstream linear data reads 0x0000 after reset
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// fifo
// ----------------------------------------------------------------------
module vtp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != FULL);
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// ----------------------------------------------------------------------
// port top
// ----------------------------------------------------------------------
module vtp_port (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hw_reset_n,
    input wire logic bclk_i,
    output logic bclk_o,
    output logic bclk_oe,
    input wire logic frame_sync_pin_i,
    output logic frame_sync_pin_o,
    output logic frame_sync_pin_oe,
    output logic ser_data_out,
    input wire logic ser_data_in,
    input wire logic [4:0] x_addr,
    input wire logic x_rd,
    input wire logic x_wr,
    input wire logic [15:0] x_wdata,
    output logic [15:0] x_rdata,
    output logic x_wr_ready,
    output logic overrun_irq,
    output logic frame_irq
);
    import vtp_pkg::*;

    // 00 none, 10 high byte, 01 low byte of a channel in this slot
    function automatic logic [1:0] slot_part(logic [4:0] map,
                                             logic lin,
                                             logic [4:0] slot);
        slot_part = 2'b00;
        if (slot == map) begin
            slot_part = lin ? 2'b10 : 2'b01;
        end else if (lin && slot == 5'(map + 5'h01)) begin
            slot_part = 2'b01;
        end
    endfunction

    logic [1:0] hw_s;
    logic [1:0] bclk_s;
    logic [1:0] fs_s;
    logic [1:0] din_s;
    logic bclk_d;
    logic fs_d;
    logic core_rst;
    logic soft_r;
    logic [3:0] cfg_r;
    logic [4:0] up_map_r [NCH];
    logic [4:0] dn_map_r [NCH];
    vtp_smp_t up_bank_r [2][NCH];
    vtp_smp_t dn_bank_r [2][NCH];
    logic bank_r;
    logic bank_on;
    logic [6:0] div_r;
    logic gclk_r;
    logic rise;
    logic fall;
    logic fs_pend_r;
    logic [7:0] bit_r;
    logic [7:0] bit_nxt;
    logic frame_start;
    logic [7:0] tx_sh_r;
    logic [7:0] tx_byte;
    logic [7:0] rx_sh_r;
    logic [7:0] rx_byte;
    logic rx_done;
    logic ovr_r;
    logic unread_any;
    logic lin;
    logic rd_up;
    vtp_dnwr_t fifo_in;
    vtp_dnwr_t fifo_out;
    logic fifo_ovalid;
    logic fifo_oready;
    logic dn_push;

    // ------------------------------------------------------------------
    // pin synchronisers and reset
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        hw_s <= {hw_s[0], hw_reset_n};
        bclk_s <= {bclk_s[0], bclk_i};
        fs_s <= {fs_s[0], frame_sync_pin_i};
        din_s <= {din_s[0], ser_data_in};
        bclk_d <= bclk_s[1];
        fs_d <= fs_s[1];
    end

    // hardware, software and bus reset all clear the datapath
    assign core_rst = srst || !hw_s[1] || soft_r;
    assign lin = cfg_r[CFG_LIN];

    // ------------------------------------------------------------------
    // configuration and slot maps
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst || !hw_s[1]) begin
            soft_r <= 1'b0;
        end else begin
            // self-clearing: one cycle of reset for the datapath
            soft_r <= x_wr && x_wdata[CFG_SRST] &&
                      (x_addr == A_CFG || x_addr == A_RESET);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !hw_s[1]) begin
            cfg_r <= CFG_RST;
        end else if (x_wr && x_addr == A_CFG) begin
            cfg_r <= {x_wdata[3:1], 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            for (int i = 0; i < NCH; i++) begin
                up_map_r[i] <= 5'(i);
                dn_map_r[i] <= 5'(i);
            end
        end else if (x_wr && x_addr[4:2] == A_UP_SLOT) begin
            up_map_r[x_addr[1:0]] <= x_wdata[4:0];
        end else if (x_wr && x_addr[4:2] == A_DN_SLOT) begin
            dn_map_r[x_addr[1:0]] <= x_wdata[4:0];
        end
    end

    // ------------------------------------------------------------------
    // time base: bit clock, bit counter, frame sync
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            div_r <= '0;
            gclk_r <= 1'b0;
        end else if (div_r == HALF_CNT) begin
            div_r <= '0;
            gclk_r <= !gclk_r;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    // all events are enables on sys_clk; no derived clock is used
    always_comb begin
        if (cfg_r[CFG_CLKSRC]) begin
            rise = (div_r == HALF_CNT) && !gclk_r;
            fall = (div_r == HALF_CNT) && gclk_r;
        end else begin
            rise = bclk_s[1] && !bclk_d;
            fall = !bclk_s[1] && bclk_d;
        end
        if (!cfg_r[CFG_FSSRC] && fs_pend_r) begin
            bit_nxt = '0;
        end else begin
            bit_nxt = bit_r + 8'h01;
        end
        frame_start = rise && (bit_nxt == '0);
        bank_on = frame_start ? !bank_r : bank_r;
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            fs_pend_r <= 1'b0;
        end else if (fs_s[1] && !fs_d) begin
            fs_pend_r <= 1'b1;
        end else if (rise) begin
            fs_pend_r <= 1'b0;
        end
    end

    // one counter serves both directions, keeping them frame aligned
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            bit_r <= 8'hff;
            frame_sync_pin_o <= 1'b0;
            bank_r <= 1'b0;
        end else if (rise) begin
            bit_r <= bit_nxt;
            frame_sync_pin_o <= (bit_nxt < FS_BITS);
            if (frame_start) begin
                bank_r <= !bank_r;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            bclk_oe <= 1'b0;
            frame_sync_pin_oe <= 1'b0;
            frame_irq <= 1'b0;
        end else begin
            bclk_oe <= cfg_r[CFG_CLKSRC];
            frame_sync_pin_oe <= cfg_r[CFG_FSSRC];
            frame_irq <= cfg_r[CFG_FSSRC] ? frame_sync_pin_o
                                          : fs_s[1];
        end
    end

    assign bclk_o = gclk_r;

    // ------------------------------------------------------------------
    // downstream serialiser
    // ------------------------------------------------------------------
    always_comb begin
        tx_byte = IDLE_BYTE;
        for (int i = 0; i < NCH; i++) begin
            case (slot_part(dn_map_r[i], lin, bit_nxt[7:3]))
                2'b10: tx_byte = dn_bank_r[bank_on][i].data[15:8];
                2'b01: tx_byte = dn_bank_r[bank_on][i].data[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            ser_data_out <= 1'b1;
            tx_sh_r <= IDLE_BYTE;
        end else if (rise && bit_nxt[2:0] == 3'h0) begin
            ser_data_out <= tx_byte[7];
            tx_sh_r <= {tx_byte[6:0], 1'b0};
        end else if (rise) begin
            ser_data_out <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // upstream deserialiser
    // ------------------------------------------------------------------
    assign rx_byte = {rx_sh_r[6:0], din_s[1]};
    assign rx_done = fall && (bit_r[2:0] == 3'h7);

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            rx_sh_r <= '0;
        end else if (fall) begin
            rx_sh_r <= rx_byte;
        end
    end

    // ------------------------------------------------------------------
    // upstream banks and overrun
    // ------------------------------------------------------------------
    assign rd_up = x_rd && (x_addr[4:2] == A_UP_PCM ||
                            x_addr[4:2] == A_UP_LIN);

    always_comb begin
        unread_any = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            unread_any = unread_any || up_bank_r[!bank_r][i].unread;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < NCH; i++) begin
                    up_bank_r[b][i] <= '{1'b0, 2'(i), DATA_RST};
                end
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (frame_start) begin
                    // old off-line bank turns on-line and starts clean
                    up_bank_r[!bank_r][i].unread <= 1'b0;
                    up_bank_r[!bank_r][i].data <= DATA_RST;
                end else if (rd_up && x_addr[1:0] == 2'(i)) begin
                    up_bank_r[!bank_r][i].unread <= 1'b0;
                end
                if (rx_done) begin
                    case (slot_part(up_map_r[i], lin, bit_r[7:3]))
                        2'b10: begin
                            up_bank_r[bank_r][i].data[15:8] <= rx_byte;
                            up_bank_r[bank_r][i].unread <= 1'b1;
                        end
                        2'b01: begin
                            up_bank_r[bank_r][i].data[7:0] <= rx_byte;
                            up_bank_r[bank_r][i].unread <= 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            ovr_r <= 1'b0;
            overrun_irq <= 1'b0;
        end else begin
            // a new overrun beats a clear in the same cycle
            if (frame_start && unread_any) begin
                ovr_r <= 1'b1;
            end else if (x_wr && x_addr == A_INT && x_wdata[INT_OVR]) begin
                ovr_r <= 1'b0;
            end
            overrun_irq <= ovr_r;
        end
    end

    // ------------------------------------------------------------------
    // downstream write path through the fifo
    // ------------------------------------------------------------------
    assign dn_push = x_wr && (x_addr[4:2] == A_DN_PCM ||
                              x_addr[4:2] == A_DN_LIN);
    assign fifo_in = '{x_addr[3], x_addr[1:0], x_wdata};
    // draining stalls on every bit clock rise, so no write lands mid-swap
    assign fifo_oready = !rise;

    vtp_fifo #(
        .W($bits(vtp_dnwr_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_dn_fifo (
        .clk(sys_clk),
        .rst(core_rst),
        .in_valid(dn_push),
        .in_ready(x_wr_ready),
        .in_data(fifo_in),
        .out_valid(fifo_ovalid),
        .out_ready(fifo_oready),
        .out_data(fifo_out)
    );

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < NCH; i++) begin
                    dn_bank_r[b][i] <= '{1'b0, 2'(i), DATA_RST};
                end
            end
        end else if (fifo_ovalid && fifo_oready) begin
            // dsp always lands in the off-line bank, fixed address
            dn_bank_r[!bank_r][fifo_out.ch].data <= fifo_out.lin
                ? fifo_out.data
                : {8'h00, fifo_out.data[7:0]};
            dn_bank_r[!bank_r][fifo_out.ch].unread <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            x_rdata <= '0;
        end else if (x_rd) begin
            x_rdata <= '0;
            case (x_addr[4:2])
                A_UP_SLOT: x_rdata <= {11'h000, up_map_r[x_addr[1:0]]};
                A_DN_SLOT: x_rdata <= {11'h000, dn_map_r[x_addr[1:0]]};
                A_UP_PCM: begin
                    // 8 sample bits plus unread flag and channel number
                    x_rdata <= {5'h00,
                        up_bank_r[!bank_r][x_addr[1:0]].unread,
                        up_bank_r[!bank_r][x_addr[1:0]].ch,
                        up_bank_r[!bank_r][x_addr[1:0]].data[7:0]};
                end
                A_DN_PCM: begin
                    x_rdata <= {5'h00,
                        dn_bank_r[!bank_r][x_addr[1:0]].unread,
                        dn_bank_r[!bank_r][x_addr[1:0]].ch,
                        dn_bank_r[!bank_r][x_addr[1:0]].data[7:0]};
                end
                A_UP_LIN: x_rdata <= up_bank_r[!bank_r][x_addr[1:0]].data;
                A_DN_LIN: x_rdata <= dn_bank_r[!bank_r][x_addr[1:0]].data;
                default: begin
                    if (x_addr == A_CFG) begin
                        x_rdata <= {12'h000, cfg_r};
                    end else if (x_addr == A_INT) begin
                        x_rdata <= {15'h0000, ovr_r};
                    end
                end
            endcase
        end
    end
endmodule

// >>> tb/vtp_port_assertions.sv
// Purpose: concurrent checks on the pins and bus of the voice tdm port
// Assumes: generated bit clock toggles every 48 sys_clk
// Notes: helper counters measure frame period and sync width
`timescale 1ns/10ps
module vtp_port_assertions
    import vtp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hw_reset_n,
    input wire logic bclk_o,
    input wire logic bclk_oe,
    input wire logic frame_sync_pin_o,
    input wire logic frame_sync_pin_oe,
    input wire logic ser_data_out,
    input wire logic [4:0] x_addr,
    input wire logic x_rd,
    input wire logic x_wr,
    input wire logic [15:0] x_wdata,
    input wire logic [15:0] x_rdata,
    input wire logic overrun_irq,
    input wire logic frame_irq
);
    logic fs_d_r;
    logic seen_r;
    logic [14:0] per_r;
    logic [9:0] hi_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst || !hw_reset_n);

    // ------------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        fs_d_r <= frame_sync_pin_o;
    end
    // the first frame after enable has no predecessor to measure against
    always_ff @(posedge sys_clk) begin
        if (srst || !hw_reset_n || !frame_sync_pin_oe) begin
            seen_r <= 1'b0;
        end else if (frame_sync_pin_o) begin
            seen_r <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        per_r <= (frame_sync_pin_o && !fs_d_r) ? 15'h0001 : per_r + 15'h0001;
    end
    always_ff @(posedge sys_clk) begin
        hi_r <= frame_sync_pin_o ? hi_r + 10'h001 : 10'h000;
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    sequence frame_start;
        $rose(frame_sync_pin_o) && frame_sync_pin_oe;
    endsequence
    sequence cfg_write;
        x_wr && x_addr == A_CFG && !x_wdata[CFG_SRST];
    endsequence

    chk_frame_period: assert property (
        frame_start |-> !seen_r || per_r == 15'h6000)
        else $error("frame period wrong");
    chk_sync_width: assert property (
        $fell(frame_sync_pin_o) && frame_sync_pin_oe |-> hi_r == 10'h300)
        else $error("frame sync width wrong");
    chk_frame_irq_rise: assert property (
        frame_start |-> ##[0:2] frame_irq)
        else $error("frame irq missed sync rise");
    chk_frame_irq_fall: assert property (
        $fell(frame_sync_pin_o) && frame_sync_pin_oe |-> ##[0:2] !frame_irq)
        else $error("frame irq missed sync fall");
    chk_oe_from_cfg: assert property (
        cfg_write |-> ##2 bclk_oe == $past(x_wdata[CFG_CLKSRC], 2)
        && frame_sync_pin_oe == $past(x_wdata[CFG_FSSRC], 2))
        else $error("output enables do not follow cfg");
    chk_unmapped_read: assert property (
        x_rd && x_addr == 5'h0d |=> x_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (
        !x_rd && !x_wr && !$past(x_wr) |=> $stable(x_rdata))
        else $error("read data moved without a read");
    chk_ovr_clear: assert property (
        x_wr && x_addr == A_INT && x_wdata[INT_OVR] && seen_r
        && per_r < 15'h5f00 |-> ##3 !overrun_irq)
        else $error("overrun irq not cleared");
    chk_ovr_at_frame: assert property (
        $rose(overrun_irq) |-> ##[0:3] frame_irq)
        else $error("overrun raised outside frame start");
    chk_data_on_rise: assert property (
        $changed(ser_data_out) && bclk_oe && $past(bclk_oe)
        |-> ##[0:2] bclk_o)
        else $error("serial data changed away from clock rise");
endmodule

bind vtp_port vtp_port_assertions vtp_port_assertions_inst (
    .sys_clk(sys_clk), .srst(srst), .hw_reset_n(hw_reset_n),
    .bclk_o(bclk_o), .bclk_oe(bclk_oe), .frame_sync_pin_o(frame_sync_pin_o),
    .frame_sync_pin_oe(frame_sync_pin_oe), .ser_data_out(ser_data_out),
    .x_addr(x_addr), .x_rd(x_rd), .x_wr(x_wr), .x_wdata(x_wdata),
    .x_rdata(x_rdata), .overrun_irq(overrun_irq), .frame_irq(frame_irq)
);

// >>> tb/vtp_codec_model.sv
// Purpose: behavioural codec on the serial voice link
// Assumes: the port drives bit clock and frame sync
// Notes: sends {3'h5, slot} in every slot, keeps the last whole frame
`timescale 1ns/10ps
module vtp_codec_model (
    input wire logic bclk,
    input wire logic fsync,
    input wire logic sdo,
    output logic sdi = 1'b1
);
    logic [7:0] rx_idx_r = 8'h00;
    logic fs_prev_r = 1'b0;
    logic [7:0] rx_nxt;
    logic [7:0] tx_idx;
    logic [7:0] tx_byte;
    logic [7:0] cur_r [32];
    logic [7:0] done_r [32];

    // sample on the falling edge; a fresh sync marks bit 0 of slot 0
    always @(negedge bclk) begin
        rx_nxt = (fsync && !fs_prev_r) ? 8'h00 : rx_idx_r + 8'h01;
        if (rx_nxt == 8'h00) begin
            done_r <= cur_r;
        end
        cur_r[rx_nxt[7:3]][3'h7 - rx_nxt[2:0]] <= sdo;
        rx_idx_r <= rx_nxt;
        fs_prev_r <= fsync;
    end

    // launch the next bit on the rising edge, msb first
    always @(posedge bclk) begin
        tx_idx = rx_idx_r + 8'h01;
        tx_byte = {3'h5, tx_idx[7:3]};
        sdi <= tx_byte[3'h7 - tx_idx[2:0]];
    end
endmodule

// >>> tb/vtp_port_tb_top.sv
// Purpose: self-checking bench for the voice tdm port
// Assumes: port generates bit clock and frame sync; codec model at far end
// Notes: two whole frames are run, about 49k cycles in all
`timescale 1ns/10ps
module vtp_port_tb_top;
    import vtp_pkg::*;
    logic sys_clk, srst, hw_reset_n, x_rd, x_wr, sdi;
    logic [4:0] x_addr;
    logic [15:0] x_wdata;
    logic [15:0] x_rdata;
    logic bclk_o, bclk_oe, fs_o, fs_oe, sdo, wr_rdy, ovr_irq, fr_irq;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] seed = 32'h29f0;
    logic [4:0] ds [4];
    logic [4:0] us [4];
    logic [7:0] smp [4];

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    vtp_port vtp_port_inst (
        .sys_clk(sys_clk), .srst(srst), .hw_reset_n(hw_reset_n),
        .bclk_i(1'b0), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
        .frame_sync_pin_i(1'b0), .frame_sync_pin_o(fs_o),
        .frame_sync_pin_oe(fs_oe), .ser_data_out(sdo), .ser_data_in(sdi),
        .x_addr(x_addr), .x_rd(x_rd), .x_wr(x_wr), .x_wdata(x_wdata),
        .x_rdata(x_rdata), .x_wr_ready(wr_rdy), .overrun_irq(ovr_irq),
        .frame_irq(fr_irq)
    );
    // undriven pins are pulled low
    vtp_codec_model vtp_codec_model_inst (
        .bclk(bclk_oe & bclk_o), .fsync(fs_oe & fs_o), .sdo(sdo), .sdi(sdi)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [15:0] up_word(input int ch, logic [4:0] s);
        return {5'h00, 1'b1, 2'(ch), 3'h5, s};
    endfunction

    task automatic print_verdict();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        x_wr = 1'b1;
        x_addr = a;
        x_wdata = d;
        @(posedge sys_clk);
        #1;
        x_wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        #1;
        x_rd = 1'b1;
        x_addr = a;
        @(posedge sys_clk);
        #1;
        x_rd = 1'b0;
        chk(x_rdata, exp);
    endtask
    // bounded wait for the next rising edge of the frame sync
    task automatic wait_fs();
        int n;
        for (n = 0; n < 60000 && fs_o !== 1'b0; n++) @(posedge sys_clk);
        for (; n < 60000 && fs_o !== 1'b1; n++) @(posedge sys_clk);
        #1;
        if (n >= 60000) begin
            mismatches++;
            print_verdict();
        end
    endtask

    initial begin
        srst = 1'b1;
        hw_reset_n = 1'b0;
        x_rd = 1'b0;
        x_wr = 1'b0;
        x_addr = 5'h00;
        x_wdata = 16'h0000;
        repeat (3) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        hw_reset_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({12'h0, wr_rdy, sdo, ovr_irq, fr_irq}, 16'h000c);
        rd(A_CFG, 16'h0000);
        rd(5'h1c, DATA_RST);
        rd(5'h0d, 16'h0000);
        wr({A_UP_SLOT, 2'h0}, 16'h0005);
        wr(A_CFG, 16'h0001);
        rd({A_UP_SLOT, 2'h0}, 16'h0000);
        wr(A_CFG, 16'h000c);
        rd(A_CFG, 16'h000c);
        chk({14'h0, bclk_oe, fs_oe}, 16'h0003);
        // random slots, kept apart per channel; last slot as a corner
        for (int i = 0; i < NCH; i++) begin
            seed = lfsr(seed);
            ds[i] = (i == 3) ? 5'h1f : {2'(i), seed[2:0]} | 5'h01;
            us[i] = {2'(i), seed[5:3]} | 5'h01;
            smp[i] = (i == 0) ? 8'h80 : seed[15:8];
            wr({A_DN_SLOT, 2'(i)}, {11'h0, ds[i]});
            wr({A_UP_SLOT, 2'(i)}, {11'h0, us[i]});
        end
        wait_fs();
        wr({A_DN_LIN, 2'h1}, seed[31:16]);
        rd({A_DN_LIN, 2'h1}, seed[31:16]);
        for (int i = 0; i < NCH; i++) begin
            wr({A_DN_PCM, 2'(i)}, {8'h00, smp[i]});
        end
        wait_fs();
        wait_fs();
        repeat (100) @(posedge sys_clk);
        for (int i = 0; i < NCH; i++) begin
            chk({8'h0, vtp_codec_model_inst.done_r[ds[i]]}, 16'(smp[i]));
            rd({A_UP_PCM, 2'(i)}, up_word(i, us[i]));
        end
        chk({8'h0, vtp_codec_model_inst.done_r[0]}, 16'(IDLE_BYTE));
        chk({15'h0, ovr_irq}, 16'h0001);
        rd(A_INT, 16'h0001);
        wr(A_INT, 16'h0001);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({15'h0, ovr_irq}, 16'h0000);
        rd(A_INT, 16'h0000);
        print_verdict();
    end
endmodule
